// ===== scmc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_defs.svh"
module scmc_top #(
  parameter int unsigned FlashCycles = `SCMC_FLASH_MS * `SCMC_CLK_KHZ
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link.
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // General-purpose pins.
  input wire logic pinAIn,
  input wire logic pinBIn,
  output logic pinAOut,
  output logic pinAOe,
  output logic pinBOut,
  output logic pinBOe,
  output logic [1:0] pinLevel,
  // Lower-priority pin claims.
  input wire logic [1:0] alarmPinEn,
  input wire logic [1:0] alarmPinVal,
  input wire logic [1:0] plainPinEn,
  input wire logic [1:0] plainPinVal,
  // Condition reports from the datapath.
  input wire logic supplyLow,
  input wire logic supplyHigh,
  input wire logic updateFail,
  input wire logic linkFail,
  input wire logic testFail,
  input wire logic alarm1,
  input wire logic alarm2,
  input wire logic convDone,
  // Inclination and DAC datapath.
  input wire scmc_pkg::scmc_incl_t inclRaw,
  input wire scmc_pkg::scmc_dac_t dacHold,
  output scmc_pkg::scmc_incl_t inclShown,
  output scmc_pkg::scmc_word_t inclOffset,
  output scmc_pkg::scmc_dac_t dacValue,
  output logic alarmIndicator,
  // Control outputs.
  output scmc_pkg::scmc_word_t samplePeriod,
  output logic [7:0] sleepCount,
  output logic selfTestOn,
  output logic reverseOn,
  output logic filterClear,
  output logic flashStart,
  output logic flashBusy
);
  import scmc_pkg::*;

  localparam scmc_incl_t TestCode = 14'(`SCMC_TEST_DEG * `SCMC_LSB_PER_DEG);
  localparam logic [23:0] FlashLast = 24'(FlashCycles - 1);

  scmc_link_if linkBus ();

  logic swRst_r;
  logic rst;
  logic tgl1_r;
  logic tgl2_r;
  logic tgl3_r;
  logic frame;
  logic isWrite;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [1:0] pin1_r;
  logic [1:0] pin2_r;
  scmc_word_t status_r;
  scmc_word_t status_nxt;
  scmc_word_t setVec;
  scmc_word_t misc_r;
  scmc_word_t smpl_r;
  logic [7:0] sleep_r;
  scmc_word_t readData_r;
  scmc_word_t offset_r;
  logic [7:0] cmd;
  logic cmdClear;
  logic storeReq;
  scmc_flash_t flash_r;
  logic [23:0] flashCnt_r;
  logic flashStart_r;
  logic filterClear_r;
  scmc_dac_t dac_r;
  logic [23:0] drCnt_r;
  logic [23:0] drPeriod_r;
  logic drActive_r;
  logic drLevel;
  logic [1:0] pinOut_r;
  logic [1:0] pinOe_r;
  scmc_incl_t inclAdj;
  scmc_incl_t inclShown_r;

  // Serial slave on the link clock.
  scmc_spi_link uLink (
    .spiSclk(spiSclk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe),
    .lnk(linkBus.link)
  );

  // A software reset acts like the reset pin for one cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      swRst_r <= 1'b0;
    end
    else
    begin
      swRst_r <= frame && cmd[`SCMC_CMD_SWRST];
    end
  end

  assign rst = !nrst || swRst_r;

  // Frame-done crossing; a soft reset leaves it alone so its frame cannot fire again.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tgl1_r <= 1'b0;
      tgl2_r <= 1'b0;
      tgl3_r <= 1'b0;
    end
    else
    begin
      tgl1_r <= linkBus.frameDone;
      tgl2_r <= tgl1_r;
      tgl3_r <= tgl2_r;
    end
  end

  // Frame layout: write flag, seven address bits, eight data bits.
  assign frame = tgl2_r && !tgl3_r;
  assign isWrite = linkBus.rxWord[15];
  assign addr = linkBus.rxWord[14:8];
  assign wdata = linkBus.rxWord[7:0];
  assign cmd = (frame && isWrite && addr == `SCMC_ADDR_CMD_LO) ? wdata : 8'h00;
  assign cmdClear = frame && cmd[`SCMC_CMD_CLEAR];

  // General-purpose pin input synchronisers.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin1_r <= 2'h0;
      pin2_r <= 2'h0;
    end
    else
    begin
      pin1_r <= {pinBIn, pinAIn};
      pin2_r <= pin1_r;
    end
  end

  // Condition vector sampled every cycle while conditions persist.
  always_comb
  begin
    setVec = 16'h0000;
    setVec[`SCMC_ST_UPD_FAIL] = updateFail;
    setVec[`SCMC_ST_SPI_FAIL] = linkFail;
    setVec[`SCMC_ST_TEST_FAIL] = testFail;
    setVec[`SCMC_ST_ALARM1] = alarm1;
    setVec[`SCMC_ST_ALARM2] = alarm2;
  end

  // Sticky flags except the two supply flags, which follow their inputs; a set in the clearing cycle wins over the clear.
  always_comb
  begin
    status_nxt = cmdClear ? 16'h0000 : status_r;
    status_nxt = status_nxt | setVec;
    status_nxt[`SCMC_ST_SUP_LOW] = supplyLow;
    status_nxt[`SCMC_ST_SUP_HIGH] = supplyHigh;
    status_nxt = status_nxt & `SCMC_STAT_MASK;
  end

  // Status word storage.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      status_r <= `SCMC_STAT_RST;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  assign alarmIndicator = |status_r;

  // Writable control bytes; status and unlisted addresses ignore writes.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      misc_r <= `SCMC_MISC_RST;
      smpl_r <= `SCMC_SMPL_RST;
      sleep_r <= 8'(`SCMC_SLEEP_RST);
    end
    else if (frame && isWrite)
    begin
      case (addr)
        `SCMC_ADDR_MISC_LO: misc_r[7:0] <= wdata & 8'(`SCMC_MISC_MASK);
        `SCMC_ADDR_MISC_HI: misc_r[15:8] <= wdata & 8'h03;
        `SCMC_ADDR_SMPL_LO: smpl_r[7:0] <= wdata;
        `SCMC_ADDR_SLEEP_LO: sleep_r <= wdata;
        default: misc_r <= misc_r;
      endcase
    end
  end

  // Read frames fetch the addressed word for the next frame to return.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      readData_r <= 16'h0000;
    end
    else if (frame && !isWrite)
    begin
      case (addr & 7'h7E)
        `SCMC_ADDR_MISC_LO: readData_r <= misc_r;
        `SCMC_ADDR_SMPL_LO: readData_r <= smpl_r;
        `SCMC_ADDR_SLEEP_LO: readData_r <= {8'h00, sleep_r};
        `SCMC_ADDR_STAT_LO: readData_r <= status_r;
        default: readData_r <= 16'h0000;
      endcase
    end
  end

  assign linkBus.txWord = readData_r;

  // Offset: factory reset zeroes it, null cancels the present reading.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      offset_r <= `SCMC_OFFS_RST;
    end
    else if (cmd[`SCMC_CMD_FACTORY])
    begin
      offset_r <= `SCMC_OFFS_RST;
    end
    else if (cmd[`SCMC_CMD_NULL])
    begin
      offset_r <= {{2{1'b0}}, 14'(-inclRaw)};
    end
  end

  // Any storing command starts the flash sequencer once.
  assign storeReq = cmd[`SCMC_CMD_FLASH] || cmd[`SCMC_CMD_FACTORY]
    || cmd[`SCMC_CMD_NULL];

  // Flash store sequencer; requests while busy are absorbed.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flash_r <= FL_IDLE;
      flashCnt_r <= 24'h000000;
      flashStart_r <= 1'b0;
    end
    else
    begin
      flashStart_r <= 1'b0;
      case (flash_r)
        FL_IDLE:
        begin
          if (storeReq)
          begin
            flash_r <= FL_STORE;
            flashCnt_r <= 24'h000000;
            flashStart_r <= 1'b1;
          end
        end
        FL_STORE:
        begin
          if (flashCnt_r == FlashLast)
          begin
            flash_r <= FL_IDLE;
          end
          else
          begin
            flashCnt_r <= flashCnt_r + 24'h000001;
          end
        end
        default: flash_r <= FL_IDLE;
      endcase
    end
  end

  // Filter history clear pulse.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      filterClear_r <= 1'b0;
    end
    else
    begin
      filterClear_r <= cmd[`SCMC_CMD_FACTORY];
    end
  end

  // DAC takes the whole held word in one edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dac_r <= 12'h000;
    end
    else if (cmd[`SCMC_CMD_DAC])
    begin
      dac_r <= dacHold;
    end
  end

  // Data-ready: set at each finished cycle, dropped a quarter period later.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      drCnt_r <= 24'h000000;
      drPeriod_r <= 24'h000000;
      drActive_r <= 1'b0;
    end
    else if (convDone)
    begin
      drCnt_r <= 24'h000000;
      drPeriod_r <= drCnt_r;
      drActive_r <= 1'b1;
    end
    else
    begin
      if (drCnt_r != 24'hFFFFFF)
      begin
        drCnt_r <= drCnt_r + 24'h000001;
      end
      if (drCnt_r >= {2'h0, drPeriod_r[23:2]})
      begin
        drActive_r <= 1'b0;
      end
    end
  end

  assign drLevel = misc_r[`SCMC_MC_POL] ? drActive_r : ~drActive_r;

  // Pin arbitration, data-ready first, then alarm, then plain control.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinOut_r <= 2'h0;
      pinOe_r <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (misc_r[`SCMC_MC_DREN] && (misc_r[`SCMC_MC_LINE] == i[0]))
        begin
          pinOut_r[i] <= drLevel;
          pinOe_r[i] <= 1'b1;
        end
        else if (alarmPinEn[i])
        begin
          pinOut_r[i] <= alarmPinVal[i];
          pinOe_r[i] <= 1'b1;
        end
        else
        begin
          pinOut_r[i] <= plainPinVal[i];
          pinOe_r[i] <= plainPinEn[i];
        end
      end
    end
  end

  // Shown angle: offset, optional reversal, or fixed self-test value.
  assign inclAdj = inclRaw + offset_r[13:0];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      inclShown_r <= 14'h0000;
    end
    else if (misc_r[`SCMC_MC_TEST])
    begin
      inclShown_r <= TestCode;
    end
    else if (misc_r[`SCMC_MC_REV])
    begin
      inclShown_r <= 14'(-inclAdj);
    end
    else
    begin
      inclShown_r <= inclAdj;
    end
  end

  // Self-test substitutes a fast period; the stored setting is untouched.
  assign samplePeriod = misc_r[`SCMC_MC_TEST] ? `SCMC_SMPL_FAST : smpl_r;

  // Output assignments.
  assign pinAOut = pinOut_r[0];
  assign pinAOe = pinOe_r[0];
  assign pinBOut = pinOut_r[1];
  assign pinBOe = pinOe_r[1];
  assign pinLevel = pin2_r;
  assign inclShown = inclShown_r;
  assign inclOffset = offset_r;
  assign dacValue = dac_r;
  assign sleepCount = sleep_r;
  assign selfTestOn = misc_r[`SCMC_MC_TEST];
  assign reverseOn = misc_r[`SCMC_MC_REV];
  assign filterClear = filterClear_r;
  assign flashStart = flashStart_r;
  assign flashBusy = (flash_r == FL_STORE);
endmodule
`default_nettype wire

// ===== scmc_defs.svh
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH
// Byte addresses seen over the serial link.
`define SCMC_ADDR_MISC_LO 7'h34
`define SCMC_ADDR_MISC_HI 7'h35
`define SCMC_ADDR_SMPL_LO 7'h36
`define SCMC_ADDR_SMPL_HI 7'h37
`define SCMC_ADDR_SLEEP_LO 7'h3A
`define SCMC_ADDR_SLEEP_HI 7'h3B
`define SCMC_ADDR_STAT_LO 7'h3C
`define SCMC_ADDR_STAT_HI 7'h3D
`define SCMC_ADDR_CMD_LO 7'h3E
`define SCMC_ADDR_CMD_HI 7'h3F
// Status bit positions.
`define SCMC_ST_SUP_LOW 0
`define SCMC_ST_SUP_HIGH 1
`define SCMC_ST_UPD_FAIL 2
`define SCMC_ST_SPI_FAIL 3
`define SCMC_ST_TEST_FAIL 5
`define SCMC_ST_ALARM1 8
`define SCMC_ST_ALARM2 9
`define SCMC_STAT_MASK 16'h032F
// Command bit positions.
`define SCMC_CMD_NULL 0
`define SCMC_CMD_FACTORY 1
`define SCMC_CMD_DAC 2
`define SCMC_CMD_FLASH 3
`define SCMC_CMD_CLEAR 4
`define SCMC_CMD_SWRST 7
// Miscellaneous control bit positions.
`define SCMC_MC_LINE 0
`define SCMC_MC_POL 1
`define SCMC_MC_DREN 2
`define SCMC_MC_TEST 8
`define SCMC_MC_REV 9
`define SCMC_MISC_MASK 16'h0307
// Reset values.
`define SCMC_STAT_RST 16'h0000
`define SCMC_MISC_RST 16'h0000
`define SCMC_SMPL_RST 16'h0008
`define SCMC_SLEEP_RST 16'h0000
`define SCMC_OFFS_RST 16'h0000
// Sample period forced during self-test.
`define SCMC_SMPL_FAST 16'h0001
// Self-test angle in degrees and output codes per degree.
`define SCMC_TEST_DEG 37
`define SCMC_LSB_PER_DEG 40
// Flash store time in ms and clock rate in kHz.
`define SCMC_FLASH_MS 50
`define SCMC_CLK_KHZ 200000
`endif

// ===== scmc_pkg.sv
package scmc_pkg;
  typedef logic [15:0] scmc_word_t;
  typedef logic [13:0] scmc_incl_t;
  typedef logic [11:0] scmc_dac_t;
  // Flash store sequencer states.
  typedef enum logic [0:0] {
    FL_IDLE = 1'b0,
    FL_STORE = 1'b1
  } scmc_flash_t;
endpackage

// ===== scmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries finished frames and the readback word between link and core.
interface scmc_link_if;
  logic frameDone;
  logic [15:0] rxWord;
  logic [15:0] txWord;
  modport link (output frameDone, output rxWord, input txWord);
  modport core (input frameDone, input rxWord, output txWord);
endinterface
`default_nettype wire

// ===== scmc_spi_link.sv
`timescale 1ns/1ps
`default_nettype none
// Serial slave, mode 3, sixteen bits a frame, on the serial clock.
module scmc_spi_link (
  // Serial pins.
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // Core side.
  scmc_link_if.link lnk
);
  logic [3:0] bitCnt_r;
  logic [14:0] rxShift_r;
  logic [15:0] txShift_r;
  logic done_r;
  logic [15:0] rxWord_r;

  // Bit counter; a deselect clears it so a broken frame cannot skew the next.
  always_ff @(posedge spiSclk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      bitCnt_r <= 4'h0;
    end
    else
    begin
      bitCnt_r <= bitCnt_r + 4'h1;
    end
  end

  // Input shifting; the sixteenth bit completes the received word.
  always_ff @(posedge spiSclk)
  begin
    rxShift_r <= {rxShift_r[13:0], spiMosi};
    if (bitCnt_r == 4'hF)
    begin
      rxWord_r <= {rxShift_r, spiMosi};
    end
  end

  // Frame-done level idles low, so no reset can leave a false edge behind.
  always_ff @(posedge spiSclk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      done_r <= 1'b0;
    end
    else if (bitCnt_r == 4'hF)
    begin
      done_r <= 1'b1;
    end
  end

  // Readback word changes only between frames and is quiet during one, so it is loaded without a crossing.
  always_ff @(negedge spiSclk)
  begin
    if (bitCnt_r == 4'h1)
    begin
      txShift_r <= {lnk.txWord[14:0], 1'b0};
    end
    else
    begin
      txShift_r <= {txShift_r[14:0], 1'b0};
    end
  end

  // The first bit is presented straight from the readback word.
  assign spiMiso = (bitCnt_r == 4'h0) ? lnk.txWord[15] : txShift_r[15];
  assign spiMisoOe = ~spiCsN;
  assign lnk.frameDone = done_r;
  assign lnk.rxWord = rxWord_r;
endmodule
`default_nettype wire

// ===== scmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the control-register block in the core clock domain.
module scmc_chk #(
  parameter int unsigned FlashCycles = 20
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin claims and drive.
  input wire logic [1:0] alarmPinEn,
  input wire logic pinBOe,
  // Condition reports.
  input wire logic supplyLow,
  input wire logic supplyHigh,
  input wire logic updateFail,
  input wire logic linkFail,
  input wire logic testFail,
  input wire logic alarm1,
  input wire logic alarm2,
  input wire logic convDone,
  // Datapath and control outputs.
  input wire scmc_pkg::scmc_incl_t inclShown,
  input wire scmc_pkg::scmc_word_t inclOffset,
  input wire scmc_pkg::scmc_dac_t dacHold,
  input wire scmc_pkg::scmc_dac_t dacValue,
  input wire logic alarmIndicator,
  input wire scmc_pkg::scmc_word_t samplePeriod,
  input wire logic selfTestOn,
  input wire logic filterClear,
  input wire logic flashStart,
  input wire logic flashBusy
);
  import scmc_pkg::*;
  logic [31:0] busyCnt_r;
  // Counts the cycles of the store now in progress.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !flashBusy)
      busyCnt_r <= '0;
    else
      busyCnt_r <= busyCnt_r + 32'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_flags_raise_alarm:
    assert property ($past(nrst) && $past(|{supplyLow, supplyHigh, updateFail, linkFail,
      testFail, alarm1, alarm2}) |-> alarmIndicator) else $error("alarm indicator missing");
  a_store_goes_busy:
    assert property (flashStart |=> flashBusy) else $error("store did not go busy");
  a_store_length:
    assert property ($fell(flashBusy) |-> busyCnt_r == FlashCycles) else $error("store length");
  a_factory_zeroes:
    assert property (filterClear |-> flashStart && inclOffset == 16'h0000)
      else $error("factory command incomplete");
  a_test_angle:
    assert property (selfTestOn && $past(selfTestOn) |-> inclShown == 14'h05C8)
      else $error("self-test angle wrong");
  a_test_period:
    assert property (selfTestOn |-> samplePeriod == 16'h0001) else $error("test period wrong");
  a_alarm_claims_pin:
    assert property ($past(nrst) && $past(alarmPinEn[1]) |-> pinBOe) else $error("pin unclaimed");
  a_dac_whole_word:
    assert property ($changed(dacValue) && dacValue != 12'h000 |-> dacValue == $past(dacHold))
      else $error("DAC took a partial word");
  c_conv: cover property (convDone);
  c_store: cover property (flashStart);
  c_test: cover property (selfTestOn);
endmodule
bind scmc_top scmc_chk #(.FlashCycles(FlashCycles)) scmc_chk_inst (
  .sys_clk(sys_clk), .nrst(nrst), .alarmPinEn(alarmPinEn), .pinBOe(pinBOe),
  .supplyLow(supplyLow), .supplyHigh(supplyHigh), .updateFail(updateFail),
  .linkFail(linkFail), .testFail(testFail), .alarm1(alarm1), .alarm2(alarm2),
  .convDone(convDone), .inclShown(inclShown), .inclOffset(inclOffset), .dacHold(dacHold),
  .dacValue(dacValue), .alarmIndicator(alarmIndicator), .samplePeriod(samplePeriod),
  .selfTestOn(selfTestOn), .filterClear(filterClear), .flashStart(flashStart),
  .flashBusy(flashBusy)
);
`default_nettype wire

// ===== scmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host master on the serial link; its clock idles high and stands still between frames.
module scmc_host_model (
  // Serial pins.
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso
);
  // Deselected and parked at power-up.
  initial
  begin
    spiSclk = 1'b1;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // One sixteen-bit frame, MSB first, returning what the device shifted out.
  task automatic xfer(input logic [15:0] txd, output logic [15:0] rxd);
    #3.3 spiCsN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #40 spiSclk = 1'b0;
      spiMosi = txd[i];
      #40 spiSclk = 1'b1;
      rxd[i] = spiMiso;
    end
    #40 spiCsN = 1'b1;
    // A released data line must not keep showing the last bit.
    spiMosi = ~spiMosi;
    #1000;
  endtask
endmodule
`default_nettype wire

// ===== test_status_command_misc_control.sv
`timescale 1ns/1ps
`default_nettype none
// Compares a settled value with its expectation and counts the outcome.
`define SCMC_CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %0t got %h want %h", $time, (got), (exp)); end end
// Self-checking bench: host model on the link, bench drives the datapath reports.
module test_status_command_misc_control;
  import scmc_pkg::*;
  logic sys_clk, nrst, pinAIn, pinBIn, convDone, sawClear, sawStart, spiSclk, spiCsN;
  logic spiMosi, spiMiso, spiMisoOe, pinAOut, pinAOe, pinBOut, pinBOe, alarmIndicator;
  logic selfTestOn, reverseOn, filterClear, flashStart, flashBusy;
  logic [1:0] alarmPinEn, alarmPinVal, plainPinEn, plainPinVal, pinLevel, oe, out;
  logic [6:0] cond;
  logic [7:0] sleepCount;
  scmc_incl_t inclRaw, inclShown;
  scmc_dac_t dacHold, dacValue;
  scmc_word_t inclOffset, samplePeriod;
  int fail_count, num_checks;
  assign oe = {pinBOe, pinAOe};
  assign out = {pinBOut, pinAOut};
  // Core clock, 5 ns period.
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  scmc_host_model scmc_host_model_inst (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso));
  scmc_top #(.FlashCycles(20)) scmc_top_inst (.sys_clk(sys_clk), .nrst(nrst),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .pinAIn(pinAIn), .pinBIn(pinBIn), .pinAOut(pinAOut),
    .pinAOe(pinAOe), .pinBOut(pinBOut), .pinBOe(pinBOe), .pinLevel(pinLevel),
    .alarmPinEn(alarmPinEn), .alarmPinVal(alarmPinVal), .plainPinEn(plainPinEn),
    .plainPinVal(plainPinVal), .supplyLow(cond[0]), .supplyHigh(cond[1]),
    .updateFail(cond[2]), .linkFail(cond[3]), .testFail(cond[4]), .alarm1(cond[5]),
    .alarm2(cond[6]), .convDone(convDone), .inclRaw(inclRaw), .dacHold(dacHold),
    .inclShown(inclShown), .inclOffset(inclOffset), .dacValue(dacValue),
    .alarmIndicator(alarmIndicator), .samplePeriod(samplePeriod), .sleepCount(sleepCount),
    .selfTestOn(selfTestOn), .reverseOn(reverseOn), .filterClear(filterClear),
    .flashStart(flashStart), .flashBusy(flashBusy));
  // Remembers the one-cycle pulses, which end long before a frame does.
  always @(posedge sys_clk)
  begin
    if (filterClear === 1'b1)
      sawClear <= 1'b1;
    if (flashStart === 1'b1)
      sawStart <= 1'b1;
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Moves to just after a later core clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Byte write and word read over the link; a read needs a second frame to return.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    scmc_host_model_inst.xfer({1'b1, a, d}, r);
    tick(1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] w);
    logic [15:0] r;
    scmc_host_model_inst.xfer({1'b0, a, 8'h00}, r);
    scmc_host_model_inst.xfer({1'b0, a, 8'h00}, w);
    tick(1);
  endtask
  // Issues a command once any earlier store has finished.
  task automatic cmd(input logic [7:0] c);
    int t;
    for (t = 0; t < 400 && flashBusy !== 1'b0; t++)
      tick(1);
    if (t == 400)
    begin
      fail_count++;
      $display("FAIL %0t store never finished", $time);
      complete_run();
    end
    else
    begin
      sawClear = 1'b0;
      sawStart = 1'b0;
      wr(7'h3E, c);
    end
  endtask
  task automatic pulse();
    convDone = 1'b1;
    tick(1);
    convDone = 1'b0;
  endtask
  // Status bit raised by condition input i.
  function automatic logic [15:0] flagBit(input int i);
    return (i < 4) ? (16'h0001 << i) : (i == 4) ? 16'h0020 : (16'h0100 << (i - 5));
  endfunction
  function automatic scmc_incl_t negIncl(input scmc_incl_t v);
    return ~v + 14'h0001;
  endfunction
  // Main sequence.
  initial
  begin
    logic [15:0] w;
    logic [7:0] cfg;
    nrst = 1'b0;
    {pinAIn, pinBIn, convDone, sawClear, sawStart, cond} = '0;
    {alarmPinEn, alarmPinVal, plainPinEn, plainPinVal} = '0;
    inclRaw = '0;
    dacHold = '0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(91));
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    tick(4);
    wr(7'h3C, 8'hFF);
    rd(7'h3C, w);
    `SCMC_CHECK(w, 16'h0000)
    rd(7'h3E, w);
    `SCMC_CHECK(w, 16'h0000)
    rd(7'h10, w);
    `SCMC_CHECK(w, 16'h0000)
    // Each condition: sets its flag, survives a clear while present, then clears.
    for (int i = 0; i < 7; i++)
    begin
      cond = 7'h01 << i;
      tick(3);
      `SCMC_CHECK(alarmIndicator, 1'b1)
      cmd(8'h10);
      rd(7'h3C, w);
      `SCMC_CHECK(w, flagBit(i))
      cond = '0;
      rd(7'h3C, w);
      `SCMC_CHECK(w, (i < 2) ? 16'h0000 : flagBit(i))
      cmd(8'h10);
      rd(7'h3C, w);
      `SCMC_CHECK(w, 16'h0000)
    end
    // Random alarm and plain claims with data-ready off; pin inputs reach their levels.
    for (int n = 0; n < 24; n++)
    begin
      w = 16'($urandom);
      {alarmPinEn, alarmPinVal, plainPinEn, plainPinVal} = w[7:0];
      {pinBIn, pinAIn} = w[9:8];
      tick(2);
      `SCMC_CHECK(pinLevel, {pinBIn, pinAIn})
      for (int p = 0; p < 2; p++)
      begin
        `SCMC_CHECK(oe[p], alarmPinEn[p] | plainPinEn[p])
        if (alarmPinEn[p] | plainPinEn[p])
          `SCMC_CHECK(out[p], alarmPinEn[p] ? alarmPinVal[p] : plainPinVal[p])
      end
    end
    // Data-ready on pin B active high, then pin A active low, over an opposing alarm.
    alarmPinEn = 2'b11;
    for (int k = 0; k < 2; k++)
    begin
      cfg = k ? 8'h04 : 8'h07;
      alarmPinVal = {2{~cfg[1]}};
      wr(7'h34, cfg);
      pulse();
      tick(39);
      pulse();
      tick(3);
      `SCMC_CHECK({oe[cfg[0]], out[cfg[0]]}, {1'b1, cfg[1]})
      tick(20);
      `SCMC_CHECK(out[cfg[0]], ~cfg[1])
    end
    {alarmPinEn, pinAIn, pinBIn} = '0;
    wr(7'h34, 8'h00);
    // Self-test, then reversed rotation.
    inclRaw = 14'($urandom);
    wr(7'h35, 8'h01);
    `SCMC_CHECK({selfTestOn, samplePeriod, inclShown}, {1'b1, 16'h0001, 14'h05C8})
    rd(7'h34, w);
    `SCMC_CHECK(w, 16'h0100)
    wr(7'h35, 8'h02);
    `SCMC_CHECK({reverseOn, samplePeriod, inclShown}, {1'b1, 16'h0008, negIncl(inclRaw)})
    wr(7'h35, 8'h00);
    // Sleep count byte written at random, seen on its port and read back.
    cfg = 8'($urandom);
    wr(7'h3A, cfg);
    rd(7'h3A, w);
    `SCMC_CHECK({spiMisoOe, sleepCount, w}, {1'b0, cfg, 8'h00, cfg})
    // Null, factory and store commands.
    cmd(8'h01);
    `SCMC_CHECK({sawStart, inclOffset, inclShown}, {3'b100, negIncl(inclRaw), 14'h0})
    cmd(8'h02);
    `SCMC_CHECK({sawStart, sawClear, inclOffset}, {2'b11, 16'h0000})
    cmd(8'h08);
    `SCMC_CHECK(sawStart, 1'b1)
    // Both data bytes stand before the latch.
    dacHold = 12'($urandom) | 12'h001;
    cmd(8'h04);
    `SCMC_CHECK(dacValue, dacHold)
    dacHold = ~dacHold;
    tick(3);
    `SCMC_CHECK(dacValue, ~dacHold)
    // Software reset returns the control words to their reset values.
    wr(7'h34, 8'h07);
    cmd(8'h80);
    rd(7'h34, w);
    `SCMC_CHECK({w, sleepCount}, {16'h0000, 8'h00})
    rd(7'h3E, w);
    `SCMC_CHECK(w, 16'h0000)
    complete_run();
  end
endmodule
`default_nettype wire
